// ---- hdl/srmux_pkg.sv ----
// Constants and carrier types for the servo/rf_sum converter output multiplexer
package srmux_pkg;
    // ----------------------------------------------------------------
    // Configuration register map (4-bit address, 8-bit data)
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_GAIN_FIRST   = 4'h0;
    localparam logic [3:0] ADDR_OFFSET_FIRST = 4'h4;
    localparam logic [3:0] ADDR_MONITOR      = 4'h8;
    localparam logic [3:0] ADDR_LASER        = 4'h9;
    localparam logic [3:0] ADDR_CLOCK        = 4'ha;
    localparam logic [3:0] ADDR_CLIP         = 4'hb;
    localparam logic [3:0] ADDR_TEST         = 4'hc;
    localparam logic [3:0] ADDR_ALL_GAIN     = 4'he;
    localparam logic [3:0] ADDR_ALL_OFFSET   = 4'hf;
    localparam int         NUM_REGS          = 16;
    localparam int         NUM_CHANNELS      = 4;
    localparam logic [7:0] REG_RESET         = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int MON_SEL_LSB   = 0;
    localparam int CUR_PATH_BIT  = 3;
    localparam int POLARITY_LSB  = 4;
    localparam int RATE_BIT      = 0;
    localparam int CLIP_OVER_BIT = 0;
    localparam int CLIP_UNDER_BIT = 1;

    // Gain: 48 steps of 0.5 dB from 6 dB, codes 0..47
    localparam logic [5:0] GAIN_CODE_MAX = 6'h2f;

    // ----------------------------------------------------------------
    // Frame and clock timing
    // ----------------------------------------------------------------
    localparam logic [2:0] SLOT_FIRST = 3'h0;
    localparam logic [2:0] SLOT_LAST  = 3'h7;
    localparam logic [1:0] DAC_DIV_LAST = 2'h2;

    typedef enum logic [2:0] {
        MON_RF_SUM, MON_DIAG_PAIR_1, MON_DIAG_PAIR_2, MON_TRK_SPOT_A, MON_TRK_SPOT_B
    } srmux_mon_t;

    typedef struct packed {
        logic       rf_over;
        logic       rf_under;
        logic [7:0] rf_code;
        logic       servo_high_clip;
        logic       servo_low_clip;
        logic [5:0] servo_code;
    } srmux_conv_t;

    typedef struct packed {
        logic       double_rate_mode;
        logic       current_path;
        logic [3:0] polarity;
        logic [2:0] monitor_sel;
        logic [5:0] laser_bias;
    } srmux_ctrl_t;
endpackage

// ---- hdl/srmux_top.sv ----
// Converter output multiplexer, clock derivation and configuration registers
//
// Behaviour
// RULE1: Partner supplies master clock, 768xFs double rate or 384xFs base rate.
// RULE2: Derive a 512xFs DAC enable and three phased converter clocks at half master. Base rate enables every master (384xFs).
// RULE3: rf_sum converter delivers 8-bit samples at the converter clock rate.
// RULE4: Servo converter cycles four channels, each at a quarter of converter rate.
// RULE5: Frame order diag1,rf,diag2,rf,trkA,rf,trkB,rf, repeating.
// RULE6: Frame marker high only in rf_sum slot before diag_pair_1.
// RULE7: Output word changes only on falling master clock edges.
// RULE8: rf_sum slots carry all eight bits, D0 least significant.
// RULE9: Servo slots carry code in bits 5:0, low clip bit 6, high clip bit 7.
// RULE10: rf_sum over/under range held sticky, readable by the partner.
// RULE11: 6-bit laser bias code sets the monitor photodiode reference.
// RULE12: Current or voltage input path is a partner-written setting.
// RULE13: Per-channel gain code, 48 steps of 0.5 dB, 6 to 29.5 dB.
// RULE14: Per-channel 6-bit offset cancellation code drives an offset DAC.
// RULE15: Partner writes rate mode and clock setup over the control port.
// RULE16: Each of four photodiode channels has its own polarity setting.
// RULE17: Monitor output source chosen from rf_sum or one servo channel.
// RULE18: Sixteen 8-bit configuration registers at a 4-bit address.
// RULE19: Broadcast addresses write all gain or all offset registers.
// RULE20: Shutdown input low resets frame and clip latches; frame restarts at slot 0.
`timescale 1ns/100ps
module srmux_top
(
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              ce,
    input  wire logic                              power_shutdown_reset_n,
    input  wire srmux_pkg::srmux_conv_t            conv,
    input  wire logic                              cfg_wr,
    input  wire logic [3:0]                        cfg_addr,
    input  wire logic [7:0]                        cfg_wdata,
    input  wire logic                              cfg_rd,
    output logic      [7:0]                        cfg_rdata,
    output logic      [7:0]                        mux_data,
    output logic                                   frame_marker,
    output logic      [1:0]                        servo_chan_sel,
    output logic                                   dac_clk_en,
    output logic      [2:0]                        adc_clk,
    output srmux_pkg::srmux_ctrl_t                 ctrl,
    output logic      [srmux_pkg::NUM_CHANNELS-1:0][5:0] gain_code,
    output logic      [srmux_pkg::NUM_CHANNELS-1:0][5:0] offset_code
);
    import srmux_pkg::*;

    function automatic logic [5:0] clamp_gain(input logic [7:0] v);
        clamp_gain = (v > {2'h0, GAIN_CODE_MAX}) ? GAIN_CODE_MAX : v[5:0];
    endfunction

    // ----------------------------------------------------------------
    // Frame slot counter and clock derivation
    // ----------------------------------------------------------------
    logic [2:0] slot_q, slot_d;
    logic [1:0] dac_div_q, dac_div_d;
    logic       dac_en_q, dac_en_d;
    logic       adc_div_q, adc_div_d;
    logic       adc_inv_q, adc_inv_d;
    logic [1:0] chan_q, chan_d;

    always_comb
    begin
        slot_d    = slot_q;
        dac_div_d = dac_div_q;
        dac_en_d  = dac_en_q;
        adc_div_d = adc_div_q;
        adc_inv_d = adc_inv_q;
        chan_d    = chan_q;
        if (ce)
        begin
            // One slot per master clock: rf_sum fills every second slot
            slot_d = power_shutdown_reset_n ? slot_q + 3'h1 : SLOT_FIRST; // see RULE5 RULE20
            chan_d = slot_d[2:1]; // see RULE4
            adc_div_d = ~adc_div_q; // see RULE2 RULE3
            // Inverse phase kept in its own flop so the pin carries no gate
            adc_inv_d = adc_div_q; // see RULE2
            dac_div_d = (dac_div_q == DAC_DIV_LAST) ? 2'h0 : dac_div_q + 2'h1;
            // Two enables per three masters gives 512xFs from 768xFs; base rate
            // cannot exceed its master, so it runs every cycle there.
            dac_en_d = ctrl.double_rate_mode ? (dac_div_d != DAC_DIV_LAST) : 1'b1; // see RULE2
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            slot_q    <= SLOT_FIRST;
            dac_div_q <= 2'h0;
            dac_en_q  <= 1'b0;
            adc_div_q <= 1'b0;
            adc_inv_q <= 1'b1;
            chan_q    <= 2'h0;
        end
        else
        begin
            slot_q    <= slot_d;
            dac_div_q <= dac_div_d;
            dac_en_q  <= dac_en_d;
            adc_div_q <= adc_div_d;
            adc_inv_q <= adc_inv_d;
            chan_q    <= chan_d;
        end
    end

    assign servo_chan_sel = chan_q;
    assign dac_clk_en     = dac_en_q;

    // ----------------------------------------------------------------
    // Falling-edge output stage
    // ----------------------------------------------------------------
    logic [7:0] data_q, data_d;
    logic       mark_q, mark_d;
    logic       adc_late_q, adc_late_d;

    always_comb
    begin
        data_d     = data_q;
        mark_d     = mark_q;
        adc_late_d = adc_late_q;
        if (ce)
        begin
            if (slot_q[0])
                data_d = conv.rf_code; // see RULE8
            else
                data_d = {conv.servo_high_clip, conv.servo_low_clip, conv.servo_code}; // see RULE9
            mark_d     = (slot_q == SLOT_LAST); // see RULE6
            adc_late_d = adc_div_q;
        end
    end

    // Partner samples on rising edges, so the word moves half a period away
    always_ff @(negedge clk or posedge rst) // see RULE7
    begin
        if (rst)
        begin
            data_q     <= 8'h00;
            mark_q     <= 1'b0;
            adc_late_q <= 1'b0;
        end
        else
        begin
            data_q     <= data_d;
            mark_q     <= mark_d;
            adc_late_q <= adc_late_d;
        end
    end

    assign mux_data     = data_q;
    assign frame_marker = mark_q;
    assign adc_clk      = {adc_late_q, adc_inv_q, adc_div_q}; // see RULE2

    // ----------------------------------------------------------------
    // Configuration registers, clip latches and control decode
    // ----------------------------------------------------------------
    logic [NUM_REGS-1:0][7:0] regs_q, regs_d;
    logic [1:0]               clip_q, clip_d;
    logic [7:0]               rdata_q, rdata_d;
    srmux_ctrl_t              ctrl_q, ctrl_d;
    logic [NUM_CHANNELS-1:0][5:0] gain_q, gain_d, offs_q, offs_d;

    always_comb
    begin
        regs_d  = regs_q;
        clip_d  = clip_q;
        rdata_d = rdata_q;
        if (ce)
        begin
            if (cfg_wr && cfg_addr != ADDR_CLIP)
            begin
                if (cfg_addr == ADDR_ALL_GAIN || cfg_addr == ADDR_ALL_OFFSET) // see RULE19
                begin
                    for (int i = 0; i < NUM_CHANNELS; i++)
                    begin
                        if (cfg_addr == ADDR_ALL_GAIN)
                            regs_d[ADDR_GAIN_FIRST + 4'(i)] = cfg_wdata;
                        else
                            regs_d[ADDR_OFFSET_FIRST + 4'(i)] = cfg_wdata;
                    end
                end
                else
                    regs_d[cfg_addr] = cfg_wdata; // see RULE18
            end
            if (cfg_rd)
            begin
                rdata_d = (cfg_addr == ADDR_CLIP) ? {6'h00, clip_q} : regs_q[cfg_addr];
                if (cfg_addr == ADDR_CLIP)
                    clip_d = 2'h0;
            end
            // New events win over the read-clear
            if (!power_shutdown_reset_n)
                clip_d = 2'h0; // see RULE20
            else
            begin
                clip_d[CLIP_OVER_BIT]  = clip_d[CLIP_OVER_BIT] | conv.rf_over; // see RULE10
                clip_d[CLIP_UNDER_BIT] = clip_d[CLIP_UNDER_BIT] | conv.rf_under;
            end
        end
        ctrl_d.double_rate_mode = regs_d[ADDR_CLOCK][RATE_BIT]; // see RULE15
        ctrl_d.current_path = regs_d[ADDR_MONITOR][CUR_PATH_BIT]; // see RULE12
        ctrl_d.polarity = regs_d[ADDR_MONITOR][POLARITY_LSB +: 4]; // see RULE16
        ctrl_d.monitor_sel = regs_d[ADDR_MONITOR][MON_SEL_LSB +: 3]; // see RULE17
        // Unlisted monitor codes fall back to rf_sum
        if (ctrl_d.monitor_sel > MON_TRK_SPOT_B)
            ctrl_d.monitor_sel = MON_RF_SUM;
        ctrl_d.laser_bias = regs_d[ADDR_LASER][5:0]; // see RULE11
        for (int i = 0; i < NUM_CHANNELS; i++)
        begin
            gain_d[i] = clamp_gain(regs_d[ADDR_GAIN_FIRST + 4'(i)]); // see RULE13
            offs_d[i] = regs_d[ADDR_OFFSET_FIRST + 4'(i)][5:0]; // see RULE14
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            regs_q  <= {NUM_REGS{REG_RESET}};
            clip_q  <= 2'h0;
            rdata_q <= 8'h00;
            ctrl_q  <= '0;
            gain_q  <= '0;
            offs_q  <= '0;
        end
        else
        begin
            regs_q  <= regs_d;
            clip_q  <= clip_d;
            rdata_q <= rdata_d;
            ctrl_q  <= ctrl_d;
            gain_q  <= gain_d;
            offs_q  <= offs_d;
        end
    end

    assign cfg_rdata   = rdata_q;
    assign ctrl        = ctrl_q;
    assign gain_code   = gain_q;
    assign offset_code = offs_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_marker_slot: assert property (ce |-> frame_marker == (slot_q == SLOT_LAST)) // see RULE6
        else $error("frame marker out of its slot");
    a_frame_wrap: assert property (ce && power_shutdown_reset_n && slot_q == SLOT_LAST // see RULE5
        |=> slot_q == SLOT_FIRST)
        else $error("frame did not wrap to first slot");
    a_rf_slot_word: assert property (ce && slot_q[0] |-> mux_data == conv.rf_code) // see RULE8
        else $error("rf_sum slot word wrong");
    a_servo_slot_word: assert property (ce && !slot_q[0] |-> mux_data == // see RULE9
        {conv.servo_high_clip, conv.servo_low_clip, conv.servo_code})
        else $error("servo slot word wrong");
    // A read of the latch or a shutdown in the cycle after the event may clear it
    a_clip_sticky: assert property (ce && power_shutdown_reset_n && conv.rf_over // see RULE10
        |=> clip_q[CLIP_OVER_BIT] ##1 (clip_q[CLIP_OVER_BIT] || ($past(ce)
        && (!$past(power_shutdown_reset_n) || ($past(cfg_rd) && $past(cfg_addr) == ADDR_CLIP)))))
        else $error("rf over-range not held");
    a_bcast_gain: assert property (ce && cfg_wr && cfg_addr == ADDR_ALL_GAIN // see RULE19
        |=> regs_q[0] == $past(cfg_wdata) && regs_q[3] == $past(cfg_wdata))
        else $error("broadcast gain write missed");
    a_gain_range: assert property (ce && cfg_wr && cfg_addr == ADDR_GAIN_FIRST // see RULE13
        |=> gain_code[0] == (($past(cfg_wdata) > {2'h0, GAIN_CODE_MAX})
        ? {2'h0, GAIN_CODE_MAX} : $past(cfg_wdata)))
        else $error("gain code beyond last step");
    a_pon_restart: assert property (ce && !power_shutdown_reset_n // see RULE20
        |=> slot_q == SLOT_FIRST && clip_q == 2'h0)
        else $error("shutdown did not restart frame");
    a_adc_half_rate: assert property (ce |=> adc_clk[0] != $past(adc_clk[0])) // see RULE3
        else $error("converter clock not at half master");
    a_servo_channel: assert property (ce && power_shutdown_reset_n // see RULE4
        |=> servo_chan_sel == slot_q[2:1])
        else $error("servo channel select off");

    c_frame_marker: cover property (frame_marker ##1 !frame_marker);
    c_bcast_offset: cover property (ce && cfg_wr && cfg_addr == ADDR_ALL_OFFSET);
    c_clip_read: cover property (clip_q != 2'h0 ##1 ce && cfg_rd && cfg_addr == ADDR_CLIP);
endmodule

// ---- sim/srmux_decoder_model.sv ----
// Behavioural decoder side that samples the multiplexed converter stream
`timescale 1ns/100ps
module srmux_decoder_model
(
    input  wire logic       clk,
    input  wire logic [7:0] mux_data,
    input  wire logic       frame_marker,
    output logic      [7:0] word,
    output logic            marker,
    output logic            moved
);
    // Takes the word on the rising edge, then looks again to catch a late change
    always @(posedge clk)
    begin
        word <= mux_data;
        marker <= frame_marker;
        #3 moved = (mux_data !== word);
    end
endmodule

// ---- sim/srmux_tb_top.sv ----
// Self-checking bench for the converter output multiplexer
`timescale 1ns/100ps
module srmux_tb_top;
    import srmux_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        shut_n = 1'b1;
    srmux_conv_t conv = '0;
    logic        cfg_wr = 1'b0;
    logic        cfg_rd = 1'b0;
    logic [3:0]  cfg_addr = 4'h0;
    logic [7:0]  cfg_wdata = 8'h00;
    logic [7:0]  cfg_rdata, mux_data, word, rd, v;
    logic        frame_marker, dac_clk_en, marker, moved, pa;
    logic [1:0]  servo_chan_sel;
    logic [2:0]  adc_clk, ph;
    srmux_ctrl_t ctrl;
    logic [NUM_CHANNELS-1:0][5:0] gain_code, offset_code;
    logic [31:0] seed = 32'hde64;
    logic [31:0] r;
    logic [7:0]  corner [3] = '{8'h2f, 8'h30, 8'h3f};
    int          n_fail = 0;
    int          n_compared = 0;
    int          n0, n1;

    always #4 clk = ~clk;

    srmux_top uut (.clk(clk), .rst(rst), .ce(ce), .power_shutdown_reset_n(shut_n),
        .conv(conv), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .mux_data(mux_data),
        .frame_marker(frame_marker), .servo_chan_sel(servo_chan_sel),
        .dac_clk_en(dac_clk_en), .adc_clk(adc_clk), .ctrl(ctrl),
        .gain_code(gain_code), .offset_code(offset_code));

    srmux_decoder_model partner (.clk(clk), .mux_data(mux_data),
        .frame_marker(frame_marker), .word(word), .marker(marker), .moved(moved));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [5:0] gain_exp(input logic [5:0] g);
        return (g > GAIN_CODE_MAX) ? GAIN_CODE_MAX : g;
    endfunction

    function automatic logic [2:0] mon_exp(input logic [2:0] m);
        return (m > 3'h4) ? 3'h0 : m;
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Every driver starts and ends just after a rising edge
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic cfg_write(input logic [3:0] a, input logic [7:0] d);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        tick();
        cfg_wr = 1'b0;
        tick();
    endtask

    task automatic cfg_read(input logic [3:0] a, output logic [7:0] d);
        cfg_rd = 1'b1;
        cfg_addr = a;
        tick();
        cfg_rd = 1'b0;
        d = cfg_rdata;
        tick();
    endtask

    // Bounded wait for the marker, so a silent stream cannot hang the run
    task automatic sync(output int n);
        n = 0;
        while (marker !== 1'b1 && n < 20)
        begin
            tick();
            n++;
        end
        ph = 3'h7;
    endtask

    // Converter inputs held for two frames; words are judged in the second frame only, other checks in both
    task automatic run_stream(input int frames);
        for (int f = 0; f < frames; f++)
        begin
            r = rnd();
            conv = {2'b00, (f == 0) ? 16'hffff : (f == 1) ? 16'h0000 : r[15:0]};
            pa = adc_clk[0];
            for (int i = 0; i < 16; i++)
            begin
                tick();
                ph = ph + 3'h1;
                chk("frame marker", ph == 3'h7, marker);
                chk("word moved", 8'h00, moved);
                chk("adc clock pair", !adc_clk[0], adc_clk[1]);
                chk("adc clock toggle", !pa, adc_clk[0]);
                chk("adc late phase", pa, adc_clk[2]);
                chk("servo channel", 2'(ph[2:1] + 2'(ph[0])), servo_chan_sel);
                pa = adc_clk[0];
                if (i >= 8)
                    chk("word", ph[0] ? conv[15:8] : conv[7:0], word);
            end
        end
        $display("stream test done");
    endtask

    task automatic dac_count(input logic [7:0] exp);
        int c;
        c = 0;
        repeat (12)
        begin
            tick();
            c += dac_clk_en;
        end
        chk("dac enables", exp, 8'(c));
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        #32000;
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        sync(n0);
        run_stream(6);
        for (int b = 0; b < 2; b++)
        begin
            conv[17-b] = 1'b1;
            tick();
            conv[17-b] = 1'b0;
            cfg_read(ADDR_CLIP, rd);
            chk("clip latch", 8'h01 << b, rd);
            cfg_read(ADDR_CLIP, rd);
            chk("clip cleared", 8'h00, rd);
        end
        cfg_write(ADDR_CLIP, 8'hff);
        cfg_read(ADDR_CLIP, rd);
        chk("clip write ignored", 8'h00, rd);
        conv[17] = 1'b1;
        tick();
        conv[17] = 1'b0;
        shut_n = 1'b0;
        tick();
        tick();
        shut_n = 1'b1;
        sync(n1);
        chk("frame restart", 8'(n0), 8'(n1));
        run_stream(2);
        cfg_read(ADDR_CLIP, rd);
        chk("clip after shutdown", 8'h00, rd);
        for (int i = 0; i < 8; i++)
        begin
            r = rnd();
            v = (i < 3) ? corner[i] : {2'b00, r[5:0]};
            cfg_write(4'(i), v);
            if (i < 4)
                chk("gain", gain_exp(v[5:0]), gain_code[i]);
            else
                chk("offset", v, offset_code[i-4]);
        end
        cfg_write(ADDR_ALL_GAIN, 8'h15);
        cfg_write(ADDR_ALL_OFFSET, 8'h2a);
        for (int i = 0; i < 4; i++)
        begin
            chk("gain all", 8'h15, gain_code[i]);
            chk("offset all", 8'h2a, offset_code[i]);
        end
        for (int m = 0; m < 6; m++)
        begin
            r = rnd();
            cfg_write(ADDR_MONITOR, {r[7:3], 3'(m)});
            chk("monitor select", mon_exp(3'(m)), ctrl.monitor_sel);
            chk("input path", r[3], ctrl.current_path);
            chk("polarity", r[7:4], ctrl.polarity);
        end
        r = rnd();
        cfg_write(ADDR_LASER, {2'b00, r[5:0]});
        chk("laser bias", r[5:0], ctrl.laser_bias);
        ce = 1'b0;
        cfg_write(ADDR_LASER, {2'b00, ~r[5:0]});
        ce = 1'b1;
        chk("laser frozen", r[5:0], ctrl.laser_bias);
        cfg_write(ADDR_CLOCK, 8'h01);
        chk("rate mode", 8'h01, ctrl.double_rate_mode);
        dac_count(8'd8);
        cfg_write(ADDR_CLOCK, 8'h00);
        dac_count(8'd12);
        for (int a = 12; a < 14; a++)
        begin
            r = rnd();
            cfg_write(4'(a), r[7:0]);
            cfg_read(4'(a), rd);
            chk("readback", r[7:0], rd);
        end
        $display("config test done");
        report_and_stop();
    end
endmodule
